/* inc/pd_supervisor_pkg.sv */
/*
  Constants, register map and carriers of the converter protection
  supervisor. Assumes one 40 MHz clock and a 32-bit APB master.
*/
// Behaviour
// - Bus overvoltage high starts debounce; fault at its end stops PWM
// - 8-bit bus overvoltage trip code, 100mV steps from 3.3V, to comparator
// - Firmware picks bus overvoltage debounce length from a set of options
// - Output undervoltage high starts its own selectable debounce count
// - Output undervoltage debounce end raises fault and stops PWM
// - 8-bit output undervoltage trip code, 100mV steps from 3V
// - MCU held inactive until main bias and core supply lockouts both clear
// - PWM locked out while any lockout, gate driver bias included, is high
// - Fixed-frequency PWM above skip threshold, pulse skipping below it
// - Diode emulation turns low-side switch off on low-side zero current
// - Diode emulation ends high-side switch conduction on its zero current
// - Both bleeders on for firmware bleed request or connector detach
// - Target raised gradually by output current times cable resistance
// - Constant-voltage target programmed at 9.93mV per code step
// - Low alert pin triggers emergency handling; open-drain or push-pull
// - Three pull-up levels, switchable pull-down, connector power switches
// - Thermistor pins: open-drain or push-pull GPIO, analog or overtemp
package pd_supervisor_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int DEB0_NS = 1000;
  localparam int DEB1_NS = 4000;
  localparam int DEB2_NS = 16000;
  localparam int DEB3_NS = 64000;
  localparam int CDC_STEP_NS = 1000;
  localparam logic [11:0] DEB0_CYC =
    12'((DEB0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] DEB1_CYC =
    12'((DEB1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] DEB2_CYC =
    12'((DEB2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] DEB3_CYC =
    12'((DEB3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0] CDC_STEP_CYC =
    6'((CDC_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int CDC_SHIFT = 6;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OVP = 8'h04;
  localparam logic [7:0] OFS_UVP = 8'h08;
  localparam logic [7:0] OFS_CV = 8'h0c;
  localparam logic [7:0] OFS_CC = 8'h10;
  localparam logic [7:0] OFS_THERM = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h20;
  localparam logic [7:0] OFS_IRQ_EN = 8'h24;
  // Control register fields
  localparam int CT_PWM_EN = 0;
  localparam int CT_FORCE_CCM = 1;
  localparam int CT_DEM_EN = 2;
  localparam int CT_BLEED = 3;
  localparam int CT_ALERT_PP = 4;
  localparam int CT_ALERT_DRV = 5;
  localparam int CT_ALERT_STOP = 6;
  localparam int CT_CDC_EN = 7;
  localparam int CT_FAULT_CLR = 8;
  localparam logic [7:0] CTRL_RST = 8'h04;
  localparam logic [9:0] OVP_RST = 10'h0ff;
  localparam logic [9:0] UVP_RST = 10'h000;
  localparam logic [11:0] CV_RST = 12'h000;
  // Synchroniser starts locked out, with pins at their pulled-up level
  localparam logic [11:0] SENSE_RST = 12'h38e;
  // Interrupt bits
  localparam int IRQ_OVP = 0;
  localparam int IRQ_UVP = 1;
  localparam int IRQ_ALERT = 2;
  localparam int IRQ_OT = 3;
  localparam int IRQ_W = 4;
  // Thermistor pin modes
  localparam logic [1:0] TM_OD = 2'h0;
  localparam logic [1:0] TM_PP = 2'h1;
  localparam logic [1:0] TM_ANALOG = 2'h2;
  localparam logic [1:0] TM_OT = 2'h3;

  typedef enum logic [3:0] {
    ST_LOCKOUT = 4'h1,
    ST_IDLE = 4'h2,
    ST_RUN = 4'h4,
    ST_FAULT = 4'h8
  } conv_state_e;

  typedef struct packed {
    logic ovp_cmp;
    logic uvp_cmp;
    logic vdd_lock;
    logic core_lock;
    logic gate_lock;
    logic comp_above;
    logic ls_zero;
    logic hs_zero;
    logic alert_pin;
    logic [1:0] therm_pin;
    logic detached;
  } sense_s;
endpackage : pd_supervisor_pkg

/* verif/sense_partner.sv */
/*
  Far-side model: comparator outputs and pin levels seen by the
  supervisor. Assumes pull-ups on the alert and thermistor pins.
*/
`timescale 1ns/1ps
module sense_partner
  import pd_supervisor_pkg::*;
(
  input wire sense_s analog_in,
  input wire logic alert_pull_low,
  input wire logic alert_out,
  input wire logic alert_oe,
  input wire logic [1:0] therm_out,
  input wire logic [1:0] therm_oe,
  input wire logic [1:0] therm_pull_low,
  output sense_s sense_out
);
  // ==========================================================
  // Pin levels
  logic alert_wire;
  logic [1:0] therm_wire;
  // Pulled up; low while any party pulls it low
  assign alert_wire = ~(alert_pull_low | (alert_oe & ~alert_out));
  assign therm_wire = (~therm_oe | therm_out) & ~therm_pull_low;
  always_comb begin
    sense_out = analog_in;
    sense_out.alert_pin = alert_wire;
    sense_out.therm_pin = therm_wire;
  end
endmodule : sense_partner

/* verif/tb_top.sv */
/*
  Self-checking bench of the protection supervisor, one task per
  scenario. Assumes the far-side model drives the sense inputs.
*/
`timescale 1ns/1ps
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin \
  err_total++; $display("FAIL %0t %s", $time, m); end end
module tb_top;
  import pd_supervisor_pkg::*;
  // ==========================================================
  // Wiring
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, alert_low = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic pready, pslverr, er, cc_pd, irq;
  logic mcu_run, pwm_run, pskip, ls_off, hs_off, alert_out, alert_oe;
  logic [1:0] bleed, cc_pu, vconn, th_out, th_oe, th_an;
  logic [1:0] th_low = 2'h0;
  logic [7:0] ovp_code, uvp_code;
  logic [9:0] iout_code = 10'h000;
  logic [11:0] cv_code;
  sense_s an = 12'h3c0;
  sense_s sense_in;
  int err_total = 0, total_checks = 0, cyc = 0;

  always #12.5 pclk = ~pclk;

  pd_converter_protection_supervisor i_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense_in(sense_in), .iout_code(iout_code),
    .mcu_run(mcu_run), .pwm_run(pwm_run), .pulse_skip_operation(pskip),
    .low_side_off(ls_off), .high_side_off(hs_off),
    .output_bleeder_pin(bleed), .ovp_trip_code(ovp_code),
    .uvp_trip_code(uvp_code), .cv_target_code(cv_code),
    .cc_pullup_sel(cc_pu), .cc_pulldown_en(cc_pd), .vconn_en(vconn),
    .alert_out(alert_out), .alert_oe(alert_oe), .therm_out(th_out),
    .therm_oe(th_oe), .therm_analog_en(th_an), .irq(irq));

  sense_partner i_far (.analog_in(an), .alert_pull_low(alert_low),
    .alert_out(alert_out), .alert_oe(alert_oe), .therm_out(th_out),
    .therm_oe(th_oe), .therm_pull_low(th_low), .sense_out(sense_in));

  // ==========================================================
  // Shared tasks
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) begin
      err_total++;
      $display("FAIL %0t %s", $time, "no pready");
    end
    d = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic tk(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tk

  task automatic cmp(input bit uv, input logic v);
    @(posedge pclk);
    if (uv) an.uvp_cmp <= v;
    else an.ovp_cmp <= v;
  endtask : cmp

  // ==========================================================
  // Scenarios
  task automatic t_lock();
    @(posedge pclk) an.core_lock <= 1'b0;
    tk(5);
    `CHK(mcu_run, 1'b0, "mcu early")
    @(posedge pclk) an.vdd_lock <= 1'b0;
    tk(5);
    `CHK(mcu_run, 1'b1, "mcu start")
    wr(OFS_CTRL, 32'h5);
    tk(5);
    `CHK(pwm_run, 1'b0, "pwm in lockout")
    @(posedge pclk) an.gate_lock <= 1'b0;
    tk(5);
    `CHK(pwm_run, 1'b1, "pwm start")
  endtask : t_lock

  task automatic t_fault(input bit uv, input int sel);
    int len, n;
    logic [7:0] a;
    len = 40 << (2 * sel);
    a = uv ? OFS_UVP : OFS_OVP;
    wr(OFS_IRQ_EN, 32'h3);
    wr(a, 32'h0a5 | (32'(sel) << 8));
    tk(4);
    `CHK(uv ? uvp_code : ovp_code, 8'ha5, "trip code")
    cmp(uv, 1'b1);
    repeat (len - 10) @(posedge pclk);
    cmp(uv, 1'b0);
    cmp(uv, 1'b1);
    repeat (len - 5) @(posedge pclk);
    #1;
    `CHK(pwm_run, 1'b1, "early trip")
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pwm_run !== 1'b0 && n < 20);
    `CHK(n < 20, 1'b1, "no trip")
    cmp(uv, 1'b0);
    tk(10);
    `CHK(pwm_run, 1'b0, "fault not held")
    rd(OFS_STATUS);
    `CHK(d[uv], 1'b1, "fault flag")
    `CHK(irq, 1'b1, "irq raise")
    rd(OFS_IRQ_STAT);
    `CHK(d[uv], 1'b1, "irq status")
    wr(OFS_IRQ_EN, 32'h0);
    tk(3);
    `CHK(irq, 1'b0, "irq mask")
    wr(OFS_IRQ_EN, 32'h3);
    wr(OFS_IRQ_CLR, 32'h3);
    wr(OFS_CTRL, 32'h104);
    wr(OFS_CTRL, 32'h005);
    tk(4);
    `CHK({irq, pwm_run}, 2'b01, "restart")
  endtask : t_fault

  task automatic t_modes();
    @(posedge pclk) an.comp_above <= 1'b0;
    tk(5);
    `CHK(pskip, 1'b1, "skip below")
    @(posedge pclk);
    an.comp_above <= 1'b1;
    an.ls_zero <= 1'b1;
    an.hs_zero <= 1'b1;
    an.detached <= 1'b1;
    tk(5);
    `CHK({pskip, ls_off, hs_off}, 3'h3, "dem on")
    `CHK(bleed, 2'h3, "bleed on")
    @(posedge pclk);
    an.comp_above <= 1'b0;
    an.detached <= 1'b0;
    wr(OFS_CTRL, 32'hb);
    tk(5);
    `CHK({pskip, ls_off, hs_off}, 3'h0, "dem off")
    `CHK(bleed, 2'h3, "bleed forced")
    @(posedge pclk) an.comp_above <= 1'b1;
    wr(OFS_CTRL, 32'h5);
  endtask : t_modes

  task automatic t_cfg();
    wr(OFS_CV, 32'h123);
    tk(5);
    `CHK(cv_code, 12'h123, "cv code")
    @(posedge pclk) iout_code <= 10'h010;
    wr(OFS_CV, 32'h40_0100);
    wr(OFS_CTRL, 32'h85);
    tk(100);
    `CHK(cv_code > 12'h100 && cv_code < 12'h105, 1'b1, "ramp")
    tk(800);
    `CHK(cv_code, 12'h110, "cdc end")
    wr(OFS_CC, 32'h1e);
    wr(OFS_THERM, 32'h6);
    tk(5);
    `CHK({cc_pu, cc_pd, vconn}, 5'h17, "cc pins")
    `CHK({th_an, th_oe[1], th_out[1]}, 4'h6, "therm")
    rd(OFS_STATUS);
    `CHK(d[10:9], 2'b01, "therm level")
    `CHK({d[27:16], d[14:11]}, {12'h110, ST_RUN}, "status")
    wr(OFS_THERM, 32'he);
    wr(OFS_IRQ_CLR, 32'h8);
    wr(OFS_IRQ_EN, 32'h8);
    tk(2);
    `CHK(irq, 1'b0, "overtemp idle")
    @(posedge pclk) th_low <= 2'h2;
    tk(6);
    `CHK(irq, 1'b1, "overtemp irq")
    @(posedge pclk) th_low <= 2'h0;
    wr(OFS_CTRL, 32'h25);
    tk(4);
    `CHK({alert_oe, alert_out}, 2'b10, "alert od")
    wr(OFS_CTRL, 32'h15);
    tk(4);
    `CHK({alert_oe, alert_out}, 2'b11, "alert pp")
    wr(OFS_CTRL, 32'h45);
    wr(OFS_IRQ_EN, 32'h4);
    @(posedge pclk) alert_low <= 1'b1;
    tk(6);
    `CHK({pwm_run, irq}, 2'b01, "alert stop")
    @(posedge pclk) alert_low <= 1'b0;
    tk(6);
    `CHK(pwm_run, 1'b1, "alert end")
    rd(8'h30);
    `CHK({er, d}, 33'h1_0000_0000, "unmapped")
  endtask : t_cfg

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    `CHK({ovp_code, alert_out}, 9'h1ff, "in reset")
    `CHK({mcu_run, pwm_run}, 2'h0, "run in reset")
    presetn <= 1'b1;
    tk(3);
    `CHK({ovp_code, alert_out}, 9'h1fe, "reset")
    `CHK({mcu_run, pwm_run}, 2'h0, "locked")
    rd(OFS_CTRL);
    `CHK({er, d}, 33'h0_0000_0004, "ctrl reset")
    t_lock();
    t_fault(1'b0, 0);
    t_fault(1'b1, 1);
    t_fault(1'b0, 2);
    t_fault(1'b1, 3);
    t_modes();
    t_cfg();
    tally_and_finish();
  end
endmodule : tb_top

/* verilog/pd_converter_protection_supervisor.sv */
/*
  Protection, lockout and mode supervisor of the buck-boost converter,
  with its APB register file. Comparator and pin inputs are asynchronous;
  the output current code comes from logic on pclk.
*/
`timescale 1ns/1ps
module pd_converter_protection_supervisor
  import pd_supervisor_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sense_s sense_in,
  input wire logic [9:0] iout_code,
  output logic mcu_run,
  output logic pwm_run,
  output logic pulse_skip_operation,
  output logic low_side_off,
  output logic high_side_off,
  output logic [1:0] output_bleeder_pin,
  output logic [7:0] ovp_trip_code,
  output logic [7:0] uvp_trip_code,
  output logic [11:0] cv_target_code,
  output logic [1:0] cc_pullup_sel,
  output logic cc_pulldown_en,
  output logic [1:0] vconn_en,
  output logic alert_out,
  output logic alert_oe,
  output logic [1:0] therm_out,
  output logic [1:0] therm_oe,
  output logic [1:0] therm_analog_en,
  output logic irq
);

  // ==========================================================
  // Helpers
  function automatic logic [11:0] deb_len(input logic [1:0] sel);
    case (sel)
      2'h0: deb_len = DEB0_CYC;
      2'h1: deb_len = DEB1_CYC;
      2'h2: deb_len = DEB2_CYC;
      default: deb_len = DEB3_CYC;
    endcase
  endfunction : deb_len

  // ==========================================================
  // Input synchroniser
  sense_s sense_m;
  sense_s s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sense_m <= SENSE_RST;
      s <= SENSE_RST;
    end else begin
      sense_m <= sense_in;
      s <= sense_m;
    end
  end

  // ==========================================================
  // Registers
  logic [7:0] ctrl;
  logic [9:0] ovp_cfg;
  logic [9:0] uvp_cfg;
  logic [11:0] cv_cfg;
  logic [7:0] rcable;
  logic [4:0] cc_cfg;
  logic [5:0] therm_cfg;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic ovp_fault;
  logic uvp_fault;
  conv_state_e state;
  conv_state_e next_state;

  wire logic acc = psel & penable;
  wire logic wr = acc & pwrite & pready;
  wire logic wr_ctrl = wr & (paddr == OFS_CTRL);
  wire logic wr_ovp = wr & (paddr == OFS_OVP);
  wire logic wr_uvp = wr & (paddr == OFS_UVP);
  wire logic wr_cv = wr & (paddr == OFS_CV);
  wire logic wr_cc = wr & (paddr == OFS_CC);
  wire logic wr_therm = wr & (paddr == OFS_THERM);
  wire logic wr_iclr = wr & (paddr == OFS_IRQ_CLR);
  wire logic wr_ien = wr & (paddr == OFS_IRQ_EN);
  wire logic fault_clr = wr_ctrl & pwdata[CT_FAULT_CLR];
  wire logic any_fault = ovp_fault | uvp_fault;
  wire logic mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_IRQ_EN);

  // Fault clears the enable so restart needs an explicit write
  wire logic [7:0] next_ctrl = wr_ctrl ? pwdata[7:0] : ctrl;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      ovp_cfg <= OVP_RST;
      uvp_cfg <= UVP_RST;
      cv_cfg <= CV_RST;
      rcable <= '0;
      cc_cfg <= '0;
      therm_cfg <= '0;
      irq_en <= '0;
    end else begin
      ctrl <= next_ctrl;
      if (state == ST_FAULT && !wr_ctrl) ctrl[CT_PWM_EN] <= 1'b0;
      if (wr_ovp) ovp_cfg <= pwdata[9:0];
      if (wr_uvp) uvp_cfg <= pwdata[9:0];
      if (wr_cv) begin
        cv_cfg <= pwdata[11:0];
        rcable <= pwdata[23:16];
      end
      if (wr_cc) cc_cfg <= pwdata[4:0];
      if (wr_therm) therm_cfg <= pwdata[5:0];
      if (wr_ien) irq_en <= pwdata[IRQ_W-1:0];
    end
  end

  // ==========================================================
  // Debounce and fault latches
  logic [11:0] ovp_cnt;
  logic [11:0] uvp_cnt;
  wire logic [11:0] ovp_len = deb_len(ovp_cfg[9:8]);
  wire logic [11:0] uvp_len = deb_len(uvp_cfg[9:8]);
  wire logic ovp_trip = s.ovp_cmp && (ovp_cnt == ovp_len - 12'h001);
  wire logic uvp_trip = s.uvp_cmp && (uvp_cnt == uvp_len - 12'h001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovp_cnt <= '0;
      uvp_cnt <= '0;
    end else begin
      if (!s.ovp_cmp) ovp_cnt <= '0;
      else if (!ovp_trip) ovp_cnt <= ovp_cnt + 12'h001;
      if (!s.uvp_cmp) uvp_cnt <= '0;
      else if (!uvp_trip) uvp_cnt <= uvp_cnt + 12'h001;
    end
  end

  // Trip wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovp_fault <= 1'b0;
      uvp_fault <= 1'b0;
    end else begin
      ovp_fault <= ovp_trip | (ovp_fault & ~fault_clr);
      uvp_fault <= uvp_trip | (uvp_fault & ~fault_clr);
    end
  end

  // ==========================================================
  // Converter state
  wire logic pwm_lock = s.vdd_lock | s.core_lock | s.gate_lock;
  wire logic alert_low = ~s.alert_pin & ~alert_oe;
  wire logic alert_kill = alert_low & ctrl[CT_ALERT_STOP];

  always_comb begin
    next_state = state;
    case (state)
      ST_LOCKOUT: if (!pwm_lock) next_state = ST_IDLE;
      ST_IDLE: if (ctrl[CT_PWM_EN] && !any_fault) next_state = ST_RUN;
      ST_RUN: begin
        if (any_fault) next_state = ST_FAULT;
        else if (!ctrl[CT_PWM_EN]) next_state = ST_IDLE;
      end
      ST_FAULT: if (!any_fault) next_state = ST_IDLE;
      default: next_state = ST_LOCKOUT;
    endcase
    if (pwm_lock) next_state = ST_LOCKOUT;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_LOCKOUT;
      pwm_run <= 1'b0;
      mcu_run <= 1'b0;
    end else begin
      state <= next_state;
      pwm_run <= (next_state == ST_RUN) & ~alert_kill;
      mcu_run <= ~(s.vdd_lock | s.core_lock);
    end
  end

  // ==========================================================
  // Switching modes and bleeders
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_skip_operation <= 1'b0;
      low_side_off <= 1'b0;
      high_side_off <= 1'b0;
      output_bleeder_pin <= '0;
    end else begin
      pulse_skip_operation <= ~ctrl[CT_FORCE_CCM] & ~s.comp_above;
      low_side_off <= ctrl[CT_DEM_EN] & s.ls_zero;
      high_side_off <= ctrl[CT_DEM_EN] & s.hs_zero;
      output_bleeder_pin <= {2{ctrl[CT_BLEED] | s.detached}};
    end
  end

  // ==========================================================
  // Cable-drop compensation
  logic [11:0] cdc_ofs;
  logic [5:0] cdc_tick;
  wire logic [17:0] cdc_prod = iout_code * rcable;
  wire logic [11:0] cdc_goal =
    ctrl[CT_CDC_EN] ? cdc_prod[CDC_SHIFT +: 12] : 12'h000;
  wire logic cdc_step = (cdc_tick == CDC_STEP_CYC - 6'h01);
  wire logic [12:0] cv_sum = {1'b0, cv_cfg} + {1'b0, cdc_ofs};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cdc_ofs <= '0;
      cdc_tick <= '0;
      cv_target_code <= CV_RST;
    end else begin
      cdc_tick <= cdc_step ? 6'h00 : cdc_tick + 6'h01;
      if (cdc_step && cdc_ofs < cdc_goal)
        cdc_ofs <= cdc_ofs + 12'h001;
      else if (cdc_step && cdc_ofs > cdc_goal)
        cdc_ofs <= cdc_ofs - 12'h001;
      cv_target_code <= cv_sum[12] ? 12'hfff : cv_sum[11:0];
    end
  end

  // ==========================================================
  // Pins
  logic [1:0] next_tout;
  logic [1:0] next_toe;
  logic [1:0] ot_now;
  logic ot_q;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_tout[i] = 1'b0;
      next_toe[i] = 1'b0;
      ot_now[i] = 1'b0;
      case (therm_cfg[2*i +: 2])
        TM_OD: next_toe[i] = ~therm_cfg[4+i];
        TM_PP: begin
          next_toe[i] = 1'b1;
          next_tout[i] = therm_cfg[4+i];
        end
        TM_OT: ot_now[i] = ~s.therm_pin[i];
        default: next_toe[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      therm_out <= '0;
      therm_oe <= '0;
      therm_analog_en <= '0;
      alert_out <= 1'b1;
      alert_oe <= 1'b0;
      ot_q <= 1'b0;
      ovp_trip_code <= OVP_RST[7:0];
      uvp_trip_code <= UVP_RST[7:0];
      cc_pullup_sel <= '0;
      cc_pulldown_en <= 1'b0;
      vconn_en <= '0;
    end else begin
      therm_out <= next_tout;
      therm_oe <= next_toe;
      therm_analog_en[0] <= therm_cfg[1:0] == TM_ANALOG;
      therm_analog_en[1] <= therm_cfg[3:2] == TM_ANALOG;
      alert_out <= ctrl[CT_ALERT_PP] & ~ctrl[CT_ALERT_DRV];
      alert_oe <= ctrl[CT_ALERT_PP] | ctrl[CT_ALERT_DRV];
      ot_q <= |ot_now;
      ovp_trip_code <= ovp_cfg[7:0];
      uvp_trip_code <= uvp_cfg[7:0];
      cc_pullup_sel <= cc_cfg[1:0];
      cc_pulldown_en <= cc_cfg[2];
      vconn_en <= cc_cfg[4:3];
    end
  end

  // ==========================================================
  // Interrupts
  logic alert_q;
  wire logic [IRQ_W-1:0] irq_evt =
    {(|ot_now) & ~ot_q, alert_low & ~alert_q, uvp_trip, ovp_trip};
  wire logic [IRQ_W-1:0] irq_clr = wr_iclr ? pwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
      alert_q <= 1'b0;
      irq <= 1'b0;
    end else begin
      alert_q <= alert_low;
      irq_stat <= irq_evt | (irq_stat & ~irq_clr);
      irq <= |(irq_stat & irq_en);
    end
  end

  // ==========================================================
  // APB read path, one wait state
  logic [31:0] rdata;
  always_comb begin
    rdata = '0;
    case (paddr)
      OFS_CTRL: rdata[7:0] = ctrl;
      OFS_OVP: rdata[9:0] = ovp_cfg;
      OFS_UVP: rdata[9:0] = uvp_cfg;
      OFS_CV: rdata = {8'h00, rcable, 4'h0, cv_cfg};
      OFS_CC: rdata[4:0] = cc_cfg;
      OFS_THERM: rdata[5:0] = therm_cfg;
      OFS_STATUS: rdata = {4'h0, cv_target_code, 1'b0, state,
        s.therm_pin, s.alert_pin, mcu_run, pulse_skip_operation,
        pwm_run, s.gate_lock, s.core_lock, s.vdd_lock,
        uvp_fault, ovp_fault};
      OFS_IRQ_STAT: rdata[IRQ_W-1:0] = irq_stat;
      OFS_IRQ_EN: rdata[IRQ_W-1:0] = irq_en;
      default: rdata = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc & ~pready;
      if (acc && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rdata;
        pslverr <= ~mapped;
      end
    end
  end

  // ==========================================================
  // Checks
  ovp_trip_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ovp_cfg[9:8] == 2'h0 && s.ovp_cmp && ovp_cnt == DEB0_CYC - 12'h001)
    |=> ovp_fault) else $error("bus overvoltage trip late");
  uvp_trip_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    (uvp_cfg[9:8] == 2'h1 && s.uvp_cmp && uvp_cnt == DEB1_CYC - 12'h001)
    |=> uvp_fault) else $error("undervoltage trip late");
  fault_stops_pwm_a: assert property (@(posedge pclk) disable iff (!presetn)
    any_fault |=> !pwm_run) else $error("pwm runs in fault");
  fault_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    ovp_fault && !fault_clr |=> ovp_fault)
    else $error("fault lost without clear");
  lockout_pwm_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.gate_lock |=> !pwm_run) else $error("pwm runs in lockout");
  mcu_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.vdd_lock || s.core_lock) |=> !mcu_run)
    else $error("mcu runs in lockout");
  skip_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl[CT_FORCE_CCM] && !s.comp_above |=> pulse_skip_operation)
    else $error("pulse skip not entered");
  low_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl[CT_DEM_EN] && s.ls_zero |=> low_side_off)
    else $error("low side not off");
  high_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl[CT_DEM_EN] && s.hs_zero |=> high_side_off)
    else $error("high side not off");
  bleed_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.detached |=> output_bleeder_pin == 2'h3)
    else $error("bleeders off after detach");
  cdc_ramp_a: assert property (@(posedge pclk) disable iff (!presetn)
    !cdc_step |=> cdc_ofs == $past(cdc_ofs))
    else $error("offset jumped between steps");

endmodule : pd_converter_protection_supervisor
